//--- core/efef_defines.svh
`ifndef EFEF_DEFINES_SVH
`define EFEF_DEFINES_SVH

// Structure
`define EFEF_NUM_CH       7
`define EFEF_NUM_UNIT     4
`define EFEF_NUM_FID      16

// Register map, byte addresses
`define EFEF_CTL_BASE     8'h00
`define EFEF_CNT_BASE     8'h20
`define EFEF_GRP_CTL      3'h0
`define EFEF_GRP_CNT      3'h1

// Control word layout and reset value
`define EFEF_EVT_LSB      0
`define EFEF_EVT_MSB      4
`define EFEF_CRS_LSB      8
`define EFEF_CRS_MSB      11
`define EFEF_FIN_LSB      12
`define EFEF_FIN_MSB      15
`define EFEF_CTL_RESET    16'h001F

// Increment events
`define EFEF_EVT_PIPE0    5'h00
`define EFEF_EVT_PIPE1    5'h01
`define EFEF_EVT_SEND     5'h02
`define EFEF_EVT_ACTIVE   5'h04
`define EFEF_EVT_STALL    5'h05

// Coarse filters
`define EFEF_CRS_NONE     4'h0
`define EFEF_CRS_VERTEX   4'h1
`define EFEF_CRS_HULL     4'h2
`define EFEF_CRS_DOMAIN   4'h3
`define EFEF_CRS_GEOM     4'h4
`define EFEF_CRS_PIXEL    4'h5
`define EFEF_CRS_GPGPU    4'h6
`define EFEF_CRS_ROW0     4'h7
`define EFEF_CRS_ASYNC    4'h9
`define EFEF_CRS_AMPL     4'hA
`define EFEF_CRS_PRIM     4'hB
`define EFEF_CRS_ANYHIT   4'hC
`define EFEF_CRS_CLOSEST  4'hD
`define EFEF_CRS_MISS     4'hE

// Fine filters
`define EFEF_FIN_NONE     4'h0
`define EFEF_FIN_HYBRID   4'h1
`define EFEF_FIN_TERNARY  4'h2
`define EFEF_FIN_BINARY   4'h3
`define EFEF_FIN_MOVE     4'h4
`define EFEF_FIN_SENDST   4'h5
`define EFEF_FIN_NUM0     4'h7
`define EFEF_FIN_NUM3     4'hA

// Instruction class flag positions
`define EFEF_CLS_HYBRID   0
`define EFEF_CLS_TERNARY  1
`define EFEF_CLS_BINARY   2
`define EFEF_CLS_MOVE     3

// Dispatcher ids (values arbitrary, match the dispatch logic)
`define EFEF_FID_VERTEX   4'h1
`define EFEF_FID_HULL     4'h2
`define EFEF_FID_DOMAIN   4'h3
`define EFEF_FID_GEOM     4'h4
`define EFEF_FID_PIXEL    4'h5
`define EFEF_FID_GPGPU    4'h6
`define EFEF_FID_ASYNC    4'h7
`define EFEF_FID_AMPL     4'h8
`define EFEF_FID_PRIM     4'h9
`define EFEF_FID_RAY      4'hA
`define EFEF_FID_RAY2     4'hB

// Ray shader-type header encodings
`define EFEF_RAY_ANYHIT   2'h0
`define EFEF_RAY_CLOSEST  2'h1
`define EFEF_RAY_MISS     2'h2

`endif

//--- core/efef_pkg.sv
package efef_pkg;
    typedef logic [4:0]  efef_evt_t;   // Increment event code
    typedef logic [3:0]  efef_crs_t;   // Coarse filter code
    typedef logic [3:0]  efef_fin_t;   // Fine filter code
    typedef logic [3:0]  efef_fid_t;   // Dispatcher function id
    typedef logic [15:0] efef_ctl_t;   // Stored control word
    typedef logic [31:0] efef_word_t;  // Bus word / counter
    typedef logic [2:0]  efef_pop_t;   // Per-cycle unit pulse count
endpackage

//--- core/efef_filter.sv
`timescale 1ns/100ps
`include "efef_defines.svh"
// Operation
// - Hull filter: instruction events need hull id
// - Hull filter: cycle events need hull thread
// - Domain/geometry/pixel/gpgpu filters behave like hull
// - Row filter passes only on row zero
// - Async filter checks async compute dispatcher
// - Amplification filter checks amplification stage dispatcher
// - Primitive-group filter checks primitive-group stage dispatcher
// - Ray filters need ray id and header
// - Ray cycle events need loaded ray thread
// - Fine code zero never suppresses
// - Fine hybrid filter needs hybrid instructions
// - Fine ternary filter needs ternary instructions
// - Fine binary filter needs binary instructions
// - A move-instruction fine filter exists
// - Send-start filter needs send dispatch start
// - Send-start with other events: undefined count
// - Unit number filters match local number
// - Seven independent channels, own control each
// - Active and stall cycle events defined
// - Pipe and send slot events defined
// - Coarse code zero never suppresses
// - All units merge into one counter

module efef_filter (
    // Clock and reset
    input  wire logic                             pclk,
    input  wire logic                             presetn,

    // APB slave
    input  wire logic                             psel,
    input  wire logic                             penable,
    input  wire logic                             pwrite,
    input  wire logic [7:0]                       paddr,
    input  wire logic [31:0]                      pwdata,
    output logic      [31:0]                      prdata,
    output logic                                  pready,
    output logic                                  pslverr,

    // Unit pipeline state, one slice per unit
    input  wire logic [`EFEF_NUM_UNIT-1:0]        unit_pipe0_active,
    input  wire logic [`EFEF_NUM_UNIT-1:0]        unit_pipe1_active,
    input  wire logic [`EFEF_NUM_UNIT-1:0]        unit_send_start,
    input  wire logic [`EFEF_NUM_UNIT-1:0]        unit_thread_loaded,
    input  wire logic [`EFEF_NUM_UNIT*4-1:0]      unit_pipe0_class,
    input  wire logic [`EFEF_NUM_UNIT*4-1:0]      unit_pipe1_class,

    // Thread dispatch state
    input  wire logic [`EFEF_NUM_UNIT*4-1:0]      unit_exec_fid,
    input  wire logic [`EFEF_NUM_UNIT*2-1:0]      unit_exec_ray_type,
    input  wire logic [`EFEF_NUM_UNIT*16-1:0]     unit_loaded_fid,

    // Unit placement
    input  wire logic [`EFEF_NUM_UNIT*2-1:0]      unit_row_id,
    input  wire logic [`EFEF_NUM_UNIT*2-1:0]      unit_local_num,

    // Per-channel merged pulse
    output logic      [`EFEF_NUM_CH-1:0]          chan_pulse
);

    ////////////////////////////////////////////////////////////////////////
    // Filter decision for one unit and one channel
    function automatic logic efef_pass(
        input efef_pkg::efef_ctl_t ctl,
        input logic                a0,
        input logic                a1,
        input logic                snd,
        input logic                ld,
        input logic [3:0]          cls0,
        input logic [3:0]          cls1,
        input efef_pkg::efef_fid_t xfid,
        input logic [1:0]          rayt,
        input logic [15:0]         lmask,
        input logic [1:0]          row,
        input logic [1:0]          num
    );
        efef_pkg::efef_evt_t evt;
        efef_pkg::efef_crs_t crs;
        efef_pkg::efef_fin_t fin;
        efef_pkg::efef_fid_t want;

        logic                inc;
        logic                inst;
        logic                cyc;
        logic                crs_ok;
        logic                fin_ok;
        logic                ray_id;
        logic [3:0]          cls;

        // Control fields
        evt  = ctl[`EFEF_EVT_MSB:`EFEF_EVT_LSB];
        crs  = ctl[`EFEF_CRS_MSB:`EFEF_CRS_LSB];
        fin  = ctl[`EFEF_FIN_MSB:`EFEF_FIN_LSB];

        // Event kind
        inst = (evt == `EFEF_EVT_PIPE0) || (evt == `EFEF_EVT_PIPE1) ||
               (evt == `EFEF_EVT_SEND);
        cyc  = (evt == `EFEF_EVT_ACTIVE) || (evt == `EFEF_EVT_STALL);

        // Either ray dispatcher
        ray_id = (xfid == `EFEF_FID_RAY) || (xfid == `EFEF_FID_RAY2);

        // Base increment event
        case (evt)
            `EFEF_EVT_PIPE0:  inc = a0;
            `EFEF_EVT_PIPE1:  inc = a1;
            `EFEF_EVT_SEND:   inc = snd;
            `EFEF_EVT_ACTIVE: inc = a0 | a1 | snd;
            `EFEF_EVT_STALL:  inc = ld & ~(a0 | a1 | snd);

            default:          inc = 1'b0;  // Unsupported or idle code
        endcase

        // Stage to look for in the stage filters
        case (crs)
            `EFEF_CRS_VERTEX: want = `EFEF_FID_VERTEX;
            `EFEF_CRS_HULL:   want = `EFEF_FID_HULL;
            `EFEF_CRS_DOMAIN: want = `EFEF_FID_DOMAIN;
            `EFEF_CRS_GEOM:   want = `EFEF_FID_GEOM;
            `EFEF_CRS_PIXEL:  want = `EFEF_FID_PIXEL;
            `EFEF_CRS_GPGPU:  want = `EFEF_FID_GPGPU;
            `EFEF_CRS_ASYNC:  want = `EFEF_FID_ASYNC;
            `EFEF_CRS_AMPL:   want = `EFEF_FID_AMPL;
            `EFEF_CRS_PRIM:   want = `EFEF_FID_PRIM;

            default:          want = `EFEF_FID_RAY;
        endcase

        // Coarse filter
        case (crs)
            `EFEF_CRS_NONE: crs_ok = 1'b1;
            `EFEF_CRS_VERTEX, `EFEF_CRS_HULL, `EFEF_CRS_DOMAIN,
            `EFEF_CRS_GEOM, `EFEF_CRS_PIXEL, `EFEF_CRS_GPGPU,
            `EFEF_CRS_ASYNC, `EFEF_CRS_AMPL, `EFEF_CRS_PRIM:
                crs_ok = (inst & (xfid == want)) | (cyc & lmask[want]);
            `EFEF_CRS_ROW0: crs_ok = (row == 2'h0);

            `EFEF_CRS_ANYHIT:
                crs_ok = (inst & ray_id & (rayt == `EFEF_RAY_ANYHIT)) |
                         (cyc & lmask[`EFEF_FID_RAY]);

            `EFEF_CRS_CLOSEST:
                crs_ok = (inst & ray_id & (rayt == `EFEF_RAY_CLOSEST)) |
                         (cyc & lmask[`EFEF_FID_RAY]);

            `EFEF_CRS_MISS:
                crs_ok = (inst & ray_id & (rayt == `EFEF_RAY_MISS)) |
                         (cyc & lmask[`EFEF_FID_RAY]);
            default: crs_ok = 1'b1;  // Undefined codes do not mask
        endcase

        // Classes on the pipes the event selects; send pipe has none
        case (evt)
            `EFEF_EVT_PIPE0:  cls = cls0;
            `EFEF_EVT_PIPE1:  cls = cls1;
            `EFEF_EVT_ACTIVE: cls = (a0 ? cls0 : 4'h0) | (a1 ? cls1 : 4'h0);
            default:          cls = 4'h0;
        endcase

        // Fine filter
        case (fin)
            `EFEF_FIN_NONE:    fin_ok = 1'b1;
            `EFEF_FIN_HYBRID:  fin_ok = cls[`EFEF_CLS_HYBRID];
            `EFEF_FIN_TERNARY: fin_ok = cls[`EFEF_CLS_TERNARY];
            `EFEF_FIN_BINARY:  fin_ok = cls[`EFEF_CLS_BINARY];
            `EFEF_FIN_MOVE:    fin_ok = cls[`EFEF_CLS_MOVE];
            // Raw send start whatever the event
            `EFEF_FIN_SENDST:  fin_ok = snd;

            default: begin
                // Unit number filters, undefined codes pass
                if ((fin >= `EFEF_FIN_NUM0) && (fin <= `EFEF_FIN_NUM3)) begin
                    fin_ok = (num == fin[1:0] + 2'h1);
                end else begin
                    fin_ok = 1'b1;
                end
            end
        endcase

        return inc & crs_ok & fin_ok;
    endfunction

    // Number of units pulsing in one channel
    function automatic efef_pkg::efef_pop_t efef_popcnt(
        input logic [`EFEF_NUM_UNIT-1:0] v
    );
        efef_pkg::efef_pop_t n;
        // Sum the unit bits
        n = 3'h0;
        for (int i = 0; i < `EFEF_NUM_UNIT; i++) begin
            n = n + {2'h0, v[i]};
        end

        return n;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // State
    efef_pkg::efef_ctl_t  ctl_r   [`EFEF_NUM_CH];      // Channel controls
    efef_pkg::efef_word_t cnt_r   [`EFEF_NUM_CH];      // Aggregate counters

    logic [`EFEF_NUM_UNIT-1:0] pulse_r [`EFEF_NUM_CH]; // Per-unit pulses
    logic [`EFEF_NUM_UNIT-1:0] pass_w  [`EFEF_NUM_CH]; // Filter results
    efef_pkg::efef_pop_t  pop_w   [`EFEF_NUM_CH];      // Pulse counts

    logic [31:0]              prdata_r;                // Read data
    logic                     pready_r;                // One wait state
    logic                     pslverr_r;               // Unmapped access

    logic [`EFEF_NUM_CH-1:0]  chan_pulse_r;            // Merged pulses

    ////////////////////////////////////////////////////////////////////////
    // APB decode
    wire         bus_setup  = psel & penable & ~pready_r;
    wire         bus_done   = psel & penable & pready_r;

    wire [2:0]   reg_grp    = paddr[7:5];
    wire [2:0]   reg_idx    = paddr[4:2];
    wire         idx_ok     = (reg_idx < 3'(`EFEF_NUM_CH));
    wire         hit_ctl    = (reg_grp == `EFEF_GRP_CTL) & idx_ok;
    wire         hit_cnt    = (reg_grp == `EFEF_GRP_CNT) & idx_ok;
    wire         mapped     = hit_ctl | hit_cnt;

    wire         wr_go      = bus_done & pwrite & mapped;

    wire [31:0]  rd_ctl     = {16'h0000, ctl_r[reg_idx]};
    wire [31:0]  rd_word    = hit_ctl ? rd_ctl :
                              hit_cnt ? cnt_r[reg_idx] : 32'h0000_0000;

    // Bus handshake and read capture; answer comes in the 2nd access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h0000_0000;
        end else begin
            // Answer, error and data stand one cycle
            pready_r  <= bus_setup;
            pslverr_r <= bus_setup & ~mapped;
            prdata_r  <= (bus_setup & ~pwrite) ? rd_word : 32'h0000_0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Channels: control, filters, pulses, aggregate counter
    for (genvar c = 0; c < `EFEF_NUM_CH; c++) begin : g_ch
        wire wr_ctl = wr_go & hit_ctl & (reg_idx == 3'(c));
        wire wr_cnt = wr_go & hit_cnt & (reg_idx == 3'(c));

        // All units share this one control word
        for (genvar u = 0; u < `EFEF_NUM_UNIT; u++) begin : g_unit
            assign pass_w[c][u] = efef_pass(ctl_r[c],
                unit_pipe0_active[u],
                unit_pipe1_active[u],
                unit_send_start[u],
                unit_thread_loaded[u],
                unit_pipe0_class[u*4 +: 4],
                unit_pipe1_class[u*4 +: 4],
                unit_exec_fid[u*4 +: 4],
                unit_exec_ray_type[u*2 +: 2],
                unit_loaded_fid[u*16 +: 16],
                unit_row_id[u*2 +: 2],
                unit_local_num[u*2 +: 2]);
        end

        assign pop_w[c] = efef_popcnt(pulse_r[c]);

        // Independent control per channel
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                ctl_r[c] <= `EFEF_CTL_RESET;
            end else if (wr_ctl) begin
                // Reserved bits are kept and read back
                ctl_r[c] <= pwdata[15:0];
            end
        end

        // Register pulses, then merge every unit into one count
        // A software load wins; the pulses of that cycle are dropped.
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                pulse_r[c]      <= '0;
                chan_pulse_r[c] <= 1'b0;
                cnt_r[c]        <= 32'h0000_0000;
            end else begin
                pulse_r[c]      <= pass_w[c];
                chan_pulse_r[c] <= |pass_w[c];

                cnt_r[c]        <= wr_cnt ? pwdata :
                                   cnt_r[c] + {29'h0, pop_w[c]};
            end
        end
    end

    // Straight from the flops
    assign prdata     = prdata_r;
    assign pready     = pready_r;
    assign pslverr    = pslverr_r;
    assign chan_pulse = chan_pulse_r;

    ////////////////////////////////////////////////////////////////////////
    // Checks on channel 0, unit 0; the row check watches unit 1, the count check sums all units
    wire [4:0] k_evt = ctl_r[0][`EFEF_EVT_MSB:`EFEF_EVT_LSB];
    wire [3:0] k_crs = ctl_r[0][`EFEF_CRS_MSB:`EFEF_CRS_LSB];
    wire [3:0] k_fin = ctl_r[0][`EFEF_FIN_MSB:`EFEF_FIN_LSB];

    // Open filters count an active cycle
    AST_OPEN_PASS: assert property (@(posedge pclk) disable iff (!presetn)
        (k_evt == `EFEF_EVT_ACTIVE) && (k_crs == `EFEF_CRS_NONE) &&
        (k_fin == `EFEF_FIN_NONE) && unit_pipe0_active[0]
        |=> pulse_r[0][0] ##1 (cnt_r[0] != $past(cnt_r[0], 1)) || $past(wr_go))
        else $error("open filters dropped an active cycle");

    // Foreign thread masked
    AST_HULL_INST: assert property (@(posedge pclk) disable iff (!presetn)
        (k_evt == `EFEF_EVT_PIPE0) && (k_crs == `EFEF_CRS_HULL) &&
        (unit_exec_fid[3:0] != `EFEF_FID_HULL) |=> !pulse_r[0][0])
        else $error("hull filter passed a foreign thread");

    // Stall follows the loaded mask
    AST_HULL_CYC: assert property (@(posedge pclk) disable iff (!presetn)
        (k_evt == `EFEF_EVT_STALL) && (k_crs == `EFEF_CRS_HULL) &&
        (k_fin == `EFEF_FIN_NONE) && unit_thread_loaded[0] &&
        !(unit_pipe0_active[0] | unit_pipe1_active[0] | unit_send_start[0])
        |=> pulse_r[0][0] == $past(unit_loaded_fid[`EFEF_FID_HULL]))
        else $error("hull cycle filter wrong");

    // Unit 1 watched, as unit 0 is often row zero
    AST_ROW_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
        (k_crs == `EFEF_CRS_ROW0) && (unit_row_id[3:2] != 2'h0)
        |=> !pulse_r[0][1])
        else $error("row filter passed a nonzero row");

    // Number filter
    AST_UNIT_NUM: assert property (@(posedge pclk) disable iff (!presetn)
        (k_fin >= `EFEF_FIN_NUM0) && (k_fin <= `EFEF_FIN_NUM3) &&
        (unit_local_num[1:0] != k_fin[1:0] + 2'h1) |=> !pulse_r[0][0])
        else $error("unit number filter mismatch");

    // Move class
    AST_MOVE_FIN: assert property (@(posedge pclk) disable iff (!presetn)
        (k_evt == `EFEF_EVT_PIPE0) && (k_fin == `EFEF_FIN_MOVE) &&
        !unit_pipe0_class[`EFEF_CLS_MOVE] |=> !pulse_r[0][0])
        else $error("move filter passed other class");

    // Send start
    AST_SEND_START: assert property (@(posedge pclk) disable iff (!presetn)
        (k_fin == `EFEF_FIN_SENDST) && !unit_send_start[0]
        |=> !pulse_r[0][0])
        else $error("send start filter passed without send");

    // Header type
    AST_RAY_HDR: assert property (@(posedge pclk) disable iff (!presetn)
        (k_evt == `EFEF_EVT_PIPE1) && (k_crs == `EFEF_CRS_MISS) &&
        (unit_exec_ray_type[1:0] != `EFEF_RAY_MISS) |=> !pulse_r[0][0])
        else $error("ray filter ignored header type");

    // Counter adds the unit count
    AST_MERGE_CNT: assert property (@(posedge pclk) disable iff (!presetn)
        !(wr_go && hit_cnt && (reg_idx == 3'h0))
        |=> cnt_r[0] == $past(cnt_r[0]) + {29'h0, $past(pop_w[0])})
        else $error("aggregate counter missed unit pulses");

endmodule // efef_filter

//--- verification/efef_unit_model.sv
`timescale 1ns/100ps
`include "efef_defines.svh"
////////////////////////////////////////////////////////////////////////////
// Stand-in for the unit pipelines and the dispatch logic. Every unit shows
// the same state; only placement differs, so a count tells how many passed
module efef_unit_model (
    // Clock
    input  wire logic        pclk,
    // Pipeline and dispatch state
    output logic [3:0]       unit_pipe0_active,
    output logic [3:0]       unit_pipe1_active,
    output logic [3:0]       unit_send_start,
    output logic [3:0]       unit_thread_loaded,
    output logic [15:0]      unit_pipe0_class,
    output logic [15:0]      unit_pipe1_class,
    output logic [15:0]      unit_exec_fid,
    output logic [7:0]       unit_exec_ray_type,
    output logic [63:0]      unit_loaded_fid,
    // Placement
    output logic [7:0]       unit_row_id,
    output logic [7:0]       unit_local_num
);
    // Unit u sits in row u and carries number u
    assign unit_row_id    = 8'hE4;
    assign unit_local_num = 8'hE4;

    ////////////////////////////////////////////////////////////////////////
    // Apply one state to all units; act is {loaded, send, pipe1, pipe0}
    task automatic put(input logic [3:0] act, input logic [3:0] cls,
        input logic [3:0] fid, input logic [1:0] rt, input logic [15:0] lm);
        unit_pipe0_active  <= {4{act[0]}};
        unit_pipe1_active  <= {4{act[1]}};
        unit_send_start    <= {4{act[2]}};
        unit_thread_loaded <= {4{act[3]}};
        unit_pipe0_class   <= {4{cls}};
        unit_pipe1_class   <= {4{cls}};
        unit_exec_fid      <= {4{fid}};
        unit_exec_ray_type <= {4{rt}};
        unit_loaded_fid    <= {4{lm}};
    endtask

    // One busy cycle, then idle again so each pulse stands alone
    task automatic drive(input logic [3:0] act, input logic [3:0] cls,
        input logic [3:0] fid, input logic [1:0] rt, input logic [15:0] lm);
        @(posedge pclk);
        put(act, cls, fid, rt, lm);
        @(posedge pclk);
        put(4'h0, 4'h0, 4'h0, 2'h0, 16'h0000);
    endtask

    // Idle from time zero
    initial begin
        put(4'h0, 4'h0, 4'h0, 2'h0, 16'h0000);
    end
endmodule // efef_unit_model

//--- verification/efef_filter_bench.sv
`timescale 1ns/100ps
`include "efef_defines.svh"
module efef_filter_bench;
    // Clock, reset and bus
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    // Unit side
    logic [3:0]  unit_pipe0_active;
    logic [3:0]  unit_pipe1_active;
    logic [3:0]  unit_send_start;
    logic [3:0]  unit_thread_loaded;
    logic [15:0] unit_pipe0_class;
    logic [15:0] unit_pipe1_class;
    logic [15:0] unit_exec_fid;
    logic [7:0]  unit_exec_ray_type;
    logic [63:0] unit_loaded_fid;
    logic [7:0]  unit_row_id;
    logic [7:0]  unit_local_num;
    logic [6:0]  chan_pulse;
    // Bookkeeping
    int          bad_count = 0;
    int          comparisons = 0;
    int          ch;
    efef_pkg::efef_crs_t crs_tab [8] = '{`EFEF_CRS_HULL, `EFEF_CRS_DOMAIN,
        `EFEF_CRS_GEOM, `EFEF_CRS_PIXEL, `EFEF_CRS_GPGPU, `EFEF_CRS_ASYNC,
        `EFEF_CRS_AMPL, `EFEF_CRS_PRIM};
    efef_pkg::efef_fid_t fid_tab [8] = '{`EFEF_FID_HULL, `EFEF_FID_DOMAIN,
        `EFEF_FID_GEOM, `EFEF_FID_PIXEL, `EFEF_FID_GPGPU, `EFEF_FID_ASYNC,
        `EFEF_FID_AMPL, `EFEF_FID_PRIM};

    efef_filter u_efef_filter (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .unit_pipe0_active,
        .unit_pipe1_active, .unit_send_start, .unit_thread_loaded,
        .unit_pipe0_class, .unit_pipe1_class, .unit_exec_fid,
        .unit_exec_ray_type, .unit_loaded_fid, .unit_row_id,
        .unit_local_num, .chan_pulse);
    efef_unit_model u_efef_unit_model (.pclk, .unit_pipe0_active,
        .unit_pipe1_active, .unit_send_start, .unit_thread_loaded,
        .unit_pipe0_class, .unit_pipe1_class, .unit_exec_fid,
        .unit_exec_ray_type, .unit_loaded_fid, .unit_row_id,
        .unit_local_num);

    ////////////////////////////////////////////////////////////////////////
    // 100 MHz clock
    initial pclk = 1'b0;
    always #5 pclk = ~pclk;

    // Compare a result with its expectation
    task automatic check_word(input string nm, input logic [31:0] exp,
        input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value %s: expected %h, seen %h", nm, exp, got);
        end
    endtask

    // Print counts and verdict, then stop
    task automatic finish_test;
        $display("comparisons %0d, mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // One APB transfer; only the watchdog ends a wait on a dead slave
    task automatic apb(input logic wr, input logic [7:0] a,
        input logic [31:0] wd, output logic [31:0] rd, output logic err);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic rd_chk(input string nm, input logic [7:0] a,
        input logic [31:0] exp, input logic exp_err);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0000_0000, r, e);
        check_word(nm, exp, r);
        check_word("slave error", {31'h0, exp_err}, {31'h0, e});
    endtask

    // Program channel ch, pulse the units once, check pulse and count
    task automatic chk(input efef_pkg::efef_evt_t evt,
        input efef_pkg::efef_crs_t crs, input efef_pkg::efef_fin_t fin,
        input logic [3:0] act, input logic [3:0] cls,
        input efef_pkg::efef_fid_t fid, input logic [1:0] rt,
        input logic [15:0] lm, input logic [2:0] exp);
        wr(8'(4 * ch), {16'h0000, fin, crs, 3'h0, evt});
        wr(8'(8'h20 + 4 * ch), 32'h0000_0000);
        u_efef_unit_model.drive(act, cls, fid, rt, lm);
        #1;
        check_word("pulse", {31'h0, exp != 3'h0}, {31'h0, chan_pulse[ch]});
        rd_chk("count", 8'(8'h20 + 4 * ch), {29'h0, exp}, 1'b0);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Watchdog, far beyond the roughly 1200 cycles the tests need
    initial begin
        #400000;
        bad_count++;
        finish_test;
    end

    // Main sequence
    initial begin
        ch = 0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        for (int c = 0; c < 7; c++) begin
            rd_chk("control", 8'(4 * c), 32'h0000_001F, 1'b0);
            rd_chk("counter", 8'(8'h20 + 4 * c), 32'h0, 1'b0);
        end
        wr(8'h00, 32'hFFFF_FFFF);
        rd_chk("control", 8'h00, 32'h0000_FFFF, 1'b0);
        wr(8'h24, 32'h1234_5678);
        rd_chk("counter", 8'h24, 32'h1234_5678, 1'b0);
        wr(8'h1C, 32'hFFFF_FFFF);
        rd_chk("unmapped", 8'h1C, 32'h0, 1'b1);
        rd_chk("unmapped", 8'h3C, 32'h0, 1'b1);
        $display("test registers done");
        // Increment events; pipe 0 on every channel in turn, the rest on channel 0
        for (int c = 0; c < 7; c++) begin
            ch = c;
            chk(5'h00, 4'h0, 4'h0, 4'h1, 4'h0, 4'h0, 2'h0, 16'h0, 3'd4);
        end
        ch = 0;
        chk(5'h00, 4'h0, 4'h0, 4'h2, 4'h0, 4'h0, 2'h0, 16'h0, 3'd0);
        chk(5'h01, 4'h0, 4'h0, 4'h2, 4'h0, 4'h0, 2'h0, 16'h0, 3'd4);
        chk(5'h02, 4'h0, 4'h0, 4'h4, 4'h0, 4'h0, 2'h0, 16'h0, 3'd4);
        chk(5'h04, 4'h0, 4'h0, 4'h2, 4'h0, 4'h0, 2'h0, 16'h0, 3'd4);
        chk(5'h04, 4'h0, 4'h0, 4'h1, 4'h0, 4'h0, 2'h0, 16'h0, 3'd4);
        chk(5'h04, 4'h0, 4'h0, 4'h8, 4'h0, 4'h0, 2'h0, 16'h0, 3'd0);
        chk(5'h05, 4'h0, 4'h0, 4'h8, 4'h0, 4'h0, 2'h0, 16'h0, 3'd4);
        chk(5'h05, 4'h0, 4'h0, 4'h9, 4'h0, 4'h0, 2'h0, 16'h0, 3'd0);
        chk(5'h1F, 4'h0, 4'h0, 4'hF, 4'h0, 4'h0, 2'h0, 16'h0, 3'd0);
        $display("test events done");
        // Stage coarse filters: instruction and cycle events
        for (int i = 0; i < 8; i++) begin
            chk(5'h00, crs_tab[i], 4'h0, 4'h1, 4'h0,
                fid_tab[i], 2'h0, 16'h0, 3'd4);
            chk(5'h02, crs_tab[i], 4'h0, 4'h4, 4'h0,
                `EFEF_FID_VERTEX, 2'h0, 16'h0, 3'd0);
            chk(5'h04, crs_tab[i], 4'h0, 4'h9, 4'h0,
                4'h0, 2'h0, 16'(1) << fid_tab[i], 3'd4);
            chk(5'h05, crs_tab[i], 4'h0, 4'h8, 4'h0,
                fid_tab[i], 2'h0, 16'h0002, 3'd0);
        end
        $display("test stage filters done");
        // Ray coarse filters: header match, either ray dispatcher
        for (int k = 0; k < 3; k++) begin
            chk(5'h00, `EFEF_CRS_ANYHIT + 4'(k), 4'h0, 4'h1, 4'h0,
                `EFEF_FID_RAY, 2'(k), 16'h0, 3'd4);
            chk(5'h01, `EFEF_CRS_ANYHIT + 4'(k), 4'h0, 4'h2, 4'h0,
                `EFEF_FID_RAY2, 2'(k), 16'h0, 3'd4);
            chk(5'h00, `EFEF_CRS_ANYHIT + 4'(k), 4'h0, 4'h1, 4'h0,
                `EFEF_FID_RAY, 2'((k + 1) % 3), 16'h0, 3'd0);
            chk(5'h04, `EFEF_CRS_ANYHIT + 4'(k), 4'h0, 4'h9, 4'h0,
                `EFEF_FID_HULL, 2'h3, 16'h0400, 3'd4);
            chk(5'h05, `EFEF_CRS_ANYHIT + 4'(k), 4'h0, 4'h8, 4'h0,
                `EFEF_FID_RAY, 2'(k), 16'h0004, 3'd0);
        end
        // Row filter keeps only the unit in row zero
        chk(5'h04, 4'h7, 4'h0, 4'h1, 4'h0, 4'h0, 2'h0, 16'h0, 3'd1);
        $display("test ray and row filters done");
        // Class fine filters, move at code four
        for (int f = 1; f < 5; f++) begin
            chk(5'h00, 4'h0, 4'(f), 4'h1, 4'(1) << (f - 1),
                4'h0, 2'h0, 16'h0, 3'd4);
            chk(5'h00, 4'h0, 4'(f), 4'h1, ~(4'(1) << (f - 1)),
                4'h0, 2'h0, 16'h0, 3'd0);
        end
        chk(5'h02, 4'h0, 4'h5, 4'h4, 4'h0, 4'h0, 2'h0, 16'h0, 3'd4);
        chk(5'h02, 4'h0, 4'h1, 4'h4, 4'hF, 4'h0, 2'h0, 16'h0, 3'd0);
        // Unit number filters pass exactly one unit
        for (int k = 0; k < 4; k++) begin
            chk(5'h00, 4'h0, 4'h7 + 4'(k), 4'h1, 4'h0,
                4'h0, 2'h0, 16'h0, 3'd1);
        end
        $display("test fine filters done");
        finish_test;
    end
endmodule // efef_filter_bench
